// ===== tb_ucs2_alpha_field_decoder.sv
// Self-checking bench for the alpha-field code point decoder.
`include "uad_cfg.svh"
module tb_ucs2_alpha_field_decoder;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk;
  logic resetn;
  logic out_ready = 1'b0;
  logic in_valid;
  uad_pkg::uad_byte_t in_byte;
  logic in_ready_ff;
  logic out_valid_ff;
  uad_pkg::uad_char_t out_char_ff;
  uad_pkg::uad_char_t exp_q[$];
  int err_count = 0;
  int cmp_count = 0;

  uad_rec_src src (.ref_clk(ref_clk), .in_ready_ff(in_ready_ff), .in_valid(in_valid), .in_byte(in_byte));
  uad_decoder i_dut (.ref_clk(ref_clk), .resetn(resetn), .in_valid(in_valid), .in_byte(in_byte),
    .in_ready_ff(in_ready_ff), .out_valid_ff(out_valid_ff), .out_char_ff(out_char_ff), .out_ready(out_ready));

  task automatic chk(input string nm, input logic [16:0] seen, input logic [16:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Expected characters of one record; the scheme is fixed by its first byte alone.
  function automatic void model(input logic [7:0] r[$]);
    logic [15:0] base;
    int n, i, k, first;
    n = r.size();
    k = exp_q.size();
    if (r[0] == `UAD_LEAD_WIDE) begin
      for (i = 1; i + 1 < n; i += 2) begin
        if (r[i] == `UAD_PAD_BYTE && r[i+1] == `UAD_PAD_BYTE) break;
        exp_q.push_back({r[i], r[i+1], 1'b0});
      end
    end else if (r[0] == `UAD_LEAD_HALF8 || r[0] == `UAD_LEAD_HALF16) begin
      base = (r[0] == `UAD_LEAD_HALF8) ? {1'b0, r[2], 7'h00} : {r[2], r[3]};
      first = (r[0] == `UAD_LEAD_HALF8) ? 3 : 4;
      for (i = first; i < n && i - first < r[1]; i++)
        exp_q.push_back({r[i][7] ? base + r[i][6:0] : {9'h000, r[i][6:0]}, 1'b0});
    end else begin
      for (i = 0; i < n && r[i] != `UAD_PAD_BYTE; i++) exp_q.push_back({9'h000, r[i][6:0], 1'b0});
    end
    if (exp_q.size() > k) exp_q[$].last = 1'b1;
  endfunction

  task automatic send(input logic [7:0] r[$]);
    uad_pkg::uad_byte_t b;
    model(r);
    foreach (r[i]) begin
      b.data = r[i];
      b.last = (i == r.size() - 1);
      src.q.push_back(b);
    end
  endtask

  task automatic rand_rec();
    logic [7:0] r[$];
    int kind, len;
    kind = $urandom_range(3);
    len = $urandom_range(8);
    case (kind)
      0: r = {8'h80};
      1: r = {8'h81, 8'($urandom_range(6)), 8'($urandom)};
      2: r = {8'h82, 8'($urandom_range(6)), 8'($urandom), 8'($urandom)};
      default: r = {8'($urandom_range(127))};
    endcase
    repeat (len) r.push_back(($urandom_range(7) == 0) ? 8'hFF : 8'($urandom));
    send(r);
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // The sink stalls at random so held characters and refused bytes are exercised.
  always @(negedge ref_clk) begin
    out_ready <= ($urandom_range(3) != 0);
  end

  always @(posedge ref_clk) begin
    if (resetn && out_valid_ff) begin
      chk("ready_while_busy", {16'h0000, in_ready_ff}, 17'h00000);
      if (out_ready) begin
        if (exp_q.size() == 0) chk("char_count", 17'h00001, 17'h00000);
        else chk("code_point", out_char_ff, exp_q.pop_front());
      end
    end
  end

  initial begin
    repeat (30000) @(posedge ref_clk);
    err_count++;
    conclude();
  end

  initial begin
    resetn = 1'b0;
    void'($urandom(32'h2429E781));
    repeat (16) @(posedge ref_clk);
    @(negedge ref_clk);
    resetn = 1'b1;
    send({8'h81, 8'h05, 8'h13, 8'h53, 8'h95, 8'hA6, 8'h41, 8'hFF, 8'hFF});
    send({8'h82, 8'h05, 8'h05, 8'h30, 8'h2D, 8'h82, 8'hD3, 8'h2D, 8'h31});
    send({8'h80, 8'h04, 8'h1F, 8'h00, 8'h41, 8'hFF, 8'h12, 8'hFF, 8'hFF});
    send({8'h80, 8'h01, 8'h02, 8'h03});
    send({8'h81, 8'h00, 8'h13, 8'h41});
    send({8'h48, 8'h49, 8'hFF, 8'h4A});
    send({8'h80, 8'h00, 8'h41, 8'hFF, 8'hFF, 8'h00, 8'h42, 8'hFF});
    repeat (60) rand_rec();
    for (int i = 0; i < 20000 && (exp_q.size() != 0 || src.q.size() != 0); i++) @(posedge ref_clk);
    repeat (20) @(posedge ref_clk);
    chk("chars_left", 17'(exp_q.size()), 17'h00000);
    chk("bytes_left", 17'(src.q.size()), 17'h00000);
    conclude();
  end
endmodule

// ===== uad_cfg.svh
// Byte codes and field constants for the alpha-field code point decoder.
`ifndef UAD_CFG_SVH
`define UAD_CFG_SVH
`define UAD_LEAD_WIDE 8'h80
`define UAD_LEAD_HALF8 8'h81
`define UAD_LEAD_HALF16 8'h82
`define UAD_PAD_BYTE 8'hFF
`define UAD_OFFSET_FLAG 7
`define UAD_ZERO_CODE 16'h0000
`define UAD_ZERO_COUNT 8'h00
`define UAD_ONE_COUNT 8'h01
`endif

// ===== uad_decoder.sv
// Alpha-field record decoder: record bytes in, 16-bit code points out.
//
// Functional notes
// - Lead byte 80h: each following byte pair is one character, high byte first.
// - Lead 80h: trailing FFh padding and an odd final byte give no character.
// - Lead 81h: second byte is the number of characters to produce.
// - Lead 81h: base is the third byte shifted left by seven.
// - Lead 81h: later bytes give 7-bit character, or base plus offset when top set.
// - Lead 82h: second byte is count, bytes three and four the full base.
// - Lead 82h: fifth and later bytes decode as 7-bit character or base plus offset.
// - Counted schemes stop at the count; FFh inside the count is a real offset.
// - One scheme, chosen by the first byte, holds for the whole record.
// - All three 16-bit schemes are implemented.
`include "uad_cfg.svh"

module uad_decoder (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic in_valid,
  input wire uad_pkg::uad_byte_t in_byte,
  output logic in_ready_ff,
  output logic out_valid_ff,
  output uad_pkg::uad_char_t out_char_ff,
  input wire logic out_ready
);
  uad_pkg::uad_state_t state_ff, nxt_state;
  uad_pkg::uad_scheme_t scheme_ff, nxt_scheme;
  logic [15:0] base_ff, nxt_base;
  logic [7:0] rem_ff, nxt_rem;
  logic [7:0] hi_ff, nxt_hi;
  logic [15:0] pend_ff, nxt_pend;
  logic pend_v_ff, nxt_pend_v;
  logic nxt_out_valid;
  uad_pkg::uad_char_t nxt_out_char;
  logic acc;
  logic [7:0] b;
  logic [15:0] off_code;
  logic [15:0] plain_code;

  assign acc = in_valid && in_ready_ff;
  assign b = in_byte.data;
  assign plain_code = {9'h000, b[6:0]};
  assign off_code = b[`UAD_OFFSET_FLAG] ? base_ff + plain_code : plain_code;

  // Uncounted schemes hold one character back so the last flag can be set
  // once the record end or padding is known, without lookahead on the input.
  always_comb begin
    nxt_state = state_ff;
    nxt_scheme = scheme_ff;
    nxt_base = base_ff;
    nxt_rem = rem_ff;
    nxt_hi = hi_ff;
    nxt_pend = pend_ff;
    nxt_pend_v = pend_v_ff;
    nxt_out_valid = out_valid_ff && !out_ready;
    nxt_out_char = out_char_ff;
    if (state_ff == uad_pkg::UAD_S_FLUSH && !nxt_out_valid) begin
      nxt_out_valid = 1'b1;
      nxt_out_char = '{code: pend_ff, last: 1'b1};
      nxt_pend_v = 1'b0;
      nxt_state = uad_pkg::UAD_S_FIRST;
    end
    if (acc) begin
      unique case (state_ff)
        uad_pkg::UAD_S_FIRST: begin
          // The lead byte fixes the scheme for the rest of the record.
          nxt_pend_v = 1'b0;
          if (b == `UAD_LEAD_WIDE) begin
            nxt_scheme = uad_pkg::UAD_SCH_WIDE;
            nxt_state = uad_pkg::UAD_S_PAIR_HI;
          end else if (b == `UAD_LEAD_HALF8) begin
            nxt_scheme = uad_pkg::UAD_SCH_HALF8;
            nxt_state = uad_pkg::UAD_S_COUNT;
          end else if (b == `UAD_LEAD_HALF16) begin
            nxt_scheme = uad_pkg::UAD_SCH_HALF16;
            nxt_state = uad_pkg::UAD_S_COUNT;
          end else begin
            nxt_scheme = uad_pkg::UAD_SCH_PLAIN;
            if (b == `UAD_PAD_BYTE) begin
              nxt_state = uad_pkg::UAD_S_DRAIN;
            end else begin
              nxt_pend = plain_code;
              nxt_pend_v = 1'b1;
              nxt_state = uad_pkg::UAD_S_PLAIN;
            end
          end
        end
        uad_pkg::UAD_S_COUNT: begin
          nxt_rem = b;
          nxt_state = uad_pkg::UAD_S_BASE_HI;
        end
        uad_pkg::UAD_S_BASE_HI: begin
          if (scheme_ff == uad_pkg::UAD_SCH_HALF8) begin
            nxt_base = {1'b0, b, 7'h00};
            nxt_state = (rem_ff == `UAD_ZERO_COUNT) ? uad_pkg::UAD_S_DRAIN : uad_pkg::UAD_S_CNT_DATA;
          end else begin
            nxt_base = {b, 8'h00};
            nxt_state = uad_pkg::UAD_S_BASE_LO;
          end
        end
        uad_pkg::UAD_S_BASE_LO: begin
          nxt_base = {base_ff[15:8], b};
          nxt_state = (rem_ff == `UAD_ZERO_COUNT) ? uad_pkg::UAD_S_DRAIN : uad_pkg::UAD_S_CNT_DATA;
        end
        uad_pkg::UAD_S_CNT_DATA: begin
          // FFh here is an offset character, never padding.
          nxt_out_valid = 1'b1;
          nxt_out_char = '{code: off_code, last: (rem_ff == `UAD_ONE_COUNT) || in_byte.last};
          nxt_rem = rem_ff - `UAD_ONE_COUNT;
          if (rem_ff == `UAD_ONE_COUNT) begin
            nxt_state = uad_pkg::UAD_S_DRAIN;
          end
        end
        uad_pkg::UAD_S_PAIR_HI: begin
          nxt_hi = b;
          nxt_state = uad_pkg::UAD_S_PAIR_LO;
        end
        uad_pkg::UAD_S_PAIR_LO: begin
          nxt_state = uad_pkg::UAD_S_PAIR_HI;
          if (hi_ff == `UAD_PAD_BYTE && b == `UAD_PAD_BYTE) begin
            // A padding pair ends the text, so later pairs are consumed and never decoded.
            nxt_state = uad_pkg::UAD_S_DRAIN;
          end else begin
            if (pend_v_ff) begin
              nxt_out_valid = 1'b1;
              nxt_out_char = '{code: pend_ff, last: 1'b0};
            end
            nxt_pend = {hi_ff, b};
            nxt_pend_v = 1'b1;
          end
        end
        uad_pkg::UAD_S_PLAIN: begin
          if (b == `UAD_PAD_BYTE) begin
            nxt_state = uad_pkg::UAD_S_DRAIN;
          end else begin
            nxt_out_valid = 1'b1;
            nxt_out_char = '{code: pend_ff, last: 1'b0};
            nxt_pend = plain_code;
          end
        end
        uad_pkg::UAD_S_DRAIN: begin
          nxt_state = uad_pkg::UAD_S_DRAIN;
        end
        default: begin
          nxt_state = uad_pkg::UAD_S_FIRST;
        end
      endcase
      if (in_byte.last) begin
        // A record end emits the held character with its last flag, or parks
        // a fresh one in the flush state when the slot was just used.
        if (nxt_pend_v && !(nxt_out_valid && !out_valid_ff)) begin
          nxt_out_valid = 1'b1;
          nxt_out_char = '{code: nxt_pend, last: 1'b1};
          nxt_pend_v = 1'b0;
          nxt_state = uad_pkg::UAD_S_FIRST;
        end else if (nxt_pend_v) begin
          nxt_state = uad_pkg::UAD_S_FLUSH;
        end else begin
          nxt_state = uad_pkg::UAD_S_FIRST;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state_ff <= uad_pkg::UAD_S_FIRST;
      scheme_ff <= uad_pkg::UAD_SCH_PLAIN;
      base_ff <= `UAD_ZERO_CODE;
      rem_ff <= `UAD_ZERO_COUNT;
      hi_ff <= `UAD_ZERO_COUNT;
    end else begin
      state_ff <= nxt_state;
      scheme_ff <= nxt_scheme;
      base_ff <= nxt_base;
      rem_ff <= nxt_rem;
      hi_ff <= nxt_hi;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pend_ff <= `UAD_ZERO_CODE;
      pend_v_ff <= 1'b0;
    end else begin
      pend_ff <= nxt_pend;
      pend_v_ff <= nxt_pend_v;
    end
  end

  // Ready is registered, so a byte is only taken when the output slot is
  // empty; this costs throughput but keeps every output straight from a flop.
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      out_valid_ff <= 1'b0;
      out_char_ff <= '{code: `UAD_ZERO_CODE, last: 1'b0};
      in_ready_ff <= 1'b0;
    end else begin
      out_valid_ff <= nxt_out_valid;
      out_char_ff <= nxt_out_char;
      in_ready_ff <= !nxt_out_valid && (nxt_state != uad_pkg::UAD_S_FLUSH);
    end
  end

  out_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    out_valid_ff && !out_ready |=> out_valid_ff && $stable(out_char_ff))
    else $error("Output changed while stalled.");

  ready_excl_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    out_valid_ff |-> !in_ready_ff)
    else $error("Input ready while output slot full.");

  scheme_hold_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    acc && state_ff != uad_pkg::UAD_S_FIRST |=> scheme_ff == $past(scheme_ff))
    else $error("Scheme changed inside a record.");

  count_take_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    acc && state_ff == uad_pkg::UAD_S_COUNT |=> rem_ff == $past(b))
    else $error("Character count not captured.");

  base8_form_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    acc && state_ff == uad_pkg::UAD_S_BASE_HI && scheme_ff == uad_pkg::UAD_SCH_HALF8
    |=> base_ff == {1'b0, $past(b), 7'h00})
    else $error("Half-page base formed wrongly.");

  lead82_sel_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    acc && state_ff == uad_pkg::UAD_S_FIRST && b == `UAD_LEAD_HALF16 && !in_byte.last
    |=> scheme_ff == uad_pkg::UAD_SCH_HALF16 ##1 1'b1)
    else $error("Wide-base scheme not selected.");

  offset_char_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    acc && state_ff == uad_pkg::UAD_S_CNT_DATA && b[`UAD_OFFSET_FLAG]
    |=> out_valid_ff && out_char_ff.code == $past(base_ff) + {9'h000, $past(b[6:0])})
    else $error("Offset character wrong.");

  septet_char_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    acc && state_ff == uad_pkg::UAD_S_CNT_DATA && !b[`UAD_OFFSET_FLAG]
    |=> out_valid_ff && out_char_ff.code == {9'h000, $past(b[6:0])})
    else $error("Seven-bit character wrong.");

  count_stop_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    acc && state_ff == uad_pkg::UAD_S_CNT_DATA && rem_ff == `UAD_ONE_COUNT
    |=> out_char_ff.last ##1 !out_valid_ff || out_char_ff.last)
    else $error("Counted record did not stop.");

  pair_form_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    acc && state_ff == uad_pkg::UAD_S_PAIR_LO && !(hi_ff == `UAD_PAD_BYTE && b == `UAD_PAD_BYTE)
    && !in_byte.last |=> pend_v_ff && pend_ff == {$past(hi_ff), $past(b)})
    else $error("Byte pair not joined high first.");

  pad_drop_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    acc && state_ff == uad_pkg::UAD_S_PAIR_LO && hi_ff == `UAD_PAD_BYTE && b == `UAD_PAD_BYTE
    && !in_byte.last |=> pend_ff == $past(pend_ff) && pend_v_ff == $past(pend_v_ff) && state_ff == uad_pkg::UAD_S_DRAIN)
    else $error("Padding pair produced a character.");

  plain_stop_a: assert property (@(posedge ref_clk) disable iff (!resetn)
    acc && state_ff == uad_pkg::UAD_S_PLAIN && b == `UAD_PAD_BYTE && !in_byte.last
    |=> state_ff == uad_pkg::UAD_S_DRAIN && !out_valid_ff)
    else $error("Plain text did not stop at padding.");
endmodule

// ===== uad_pkg.sv
// Types shared by the alpha-field code point decoder.
package uad_pkg;
  typedef enum logic [3:0] {
    UAD_S_FIRST = 4'h0,
    UAD_S_COUNT = 4'h1,
    UAD_S_BASE_HI = 4'h2,
    UAD_S_BASE_LO = 4'h3,
    UAD_S_PAIR_HI = 4'h4,
    UAD_S_PAIR_LO = 4'h5,
    UAD_S_CNT_DATA = 4'h6,
    UAD_S_PLAIN = 4'h7,
    UAD_S_DRAIN = 4'h8,
    UAD_S_FLUSH = 4'h9
  } uad_state_t;

  typedef enum logic [1:0] {
    UAD_SCH_PLAIN = 2'h0,
    UAD_SCH_WIDE = 2'h1,
    UAD_SCH_HALF8 = 2'h2,
    UAD_SCH_HALF16 = 2'h3
  } uad_scheme_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } uad_byte_t;

  typedef struct packed {
    logic [15:0] code;
    logic last;
  } uad_char_t;
endpackage

// ===== uad_rec_src.sv
// Record byte source standing in for the card file read path.
module uad_rec_src (
  input wire logic ref_clk,
  input wire logic in_ready_ff,
  output logic in_valid,
  output uad_pkg::uad_byte_t in_byte
);
  timeunit 1ns;
  timeprecision 100ps;
  uad_pkg::uad_byte_t q[$];
  logic took;

  initial begin
    in_valid = 1'b0;
    in_byte = '0;
    took = 1'b0;
  end

  always @(posedge ref_clk) begin
    took <= in_valid && in_ready_ff;
  end

  // A byte is held until taken; idle gaps invert the data so stale bytes never look valid.
  always @(negedge ref_clk) begin
    if (!in_valid || took) begin
      if (q.size() > 0 && $urandom_range(3) != 0) begin
        in_byte <= q.pop_front();
        in_valid <= 1'b1;
      end else begin
        in_valid <= 1'b0;
        in_byte.data <= ~in_byte.data;
      end
    end
  end
endmodule
